// ===== src/fic_top.sv
// Four-level priority interrupt controller with APB register access
//
// What this block does
// - Accept thirteen sources, each given one of four priority levels.
// - Each source has an enable bit; disabled sources are never serviced.
// - Global enable bit in enable register zero gates every source; the o_wake output is not gated by it.
// - Priority level per source from one high-register and one low bit.
// - Preempt a running routine only with strictly higher priority.
// - A routine at the top level is never interrupted.
// - Simultaneous requests: higher priority level serviced first.
// - Equal-level ties resolved by fixed polling order, only for ties.
// - Tie order: ext0, brownout, watchdog, ... timer i last.
// - Fixed vector per source, step eight, gaps before watchdog, timer i.
// - Serial transmit and receive flags share one request and vector.
// - Only ext, brownout, keyboard, comparators, watchdog, converter wake from power-down.
// - Level mode: low level on active-low pin raises a request.
// - Edge mode: sample high then next sample low sets the flag.
// - Edge mode flag cleared by hardware when its routine is entered.
// - Level mode: pin still low at routine end gives another interrupt.
// - Level mode: request flag follows the pin, no software clear.
// - Enabled external interrupt wakes the core from idle or power-down.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "fic_regs.svh"

module fic_top (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // External interrupt pins, active low
   input wire logic [1:0] i_ext_irq_pin_n,
   // Peripheral request levels
   input wire logic i_timer0_req,
   input wire logic i_timer1_req,
   input wire logic i_serial_tx_flag,
   input wire logic i_serial_rx_flag,
   input wire logic i_bod_req,
   input wire logic i_i2c_req,
   input wire logic i_kbd_req,
   input wire logic i_cmp2_req,
   input wire logic i_wdt_req,
   input wire logic i_adc_req,
   input wire logic i_cmp1_req,
   input wire logic i_timer_i_req,
   // CPU side
   input wire logic i_irq_ack,
   input wire logic i_irq_return,
   input wire logic i_idle,
   input wire logic i_power_down,
   output logic o_irq_req,
   output logic [15:0] o_irq_vector,
   output fic_pkg::fic_level_t o_irq_level,
   output logic o_wake
);
   import fic_pkg::*;

   fic_state_t s_reg;
   fic_state_t s_next;

   // ==========================================================
   // Arbitration helpers

   // Highest in-service level, or -1 when nothing is running
   function automatic logic [2:0] top_active(input logic [3:0] act);
      logic [2:0] r;
      r = 3'b111;
      for (int i = 0; i < 4; i++) begin
         if (act[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction : top_active

   // Vector address, with unused slots ahead of the watchdog and timer i
   function automatic logic [15:0] vec_of(input fic_src_t src);
      logic [15:0] slot;
      slot = {12'h000, src};
      if (src >= `FIC_VEC_GAP_SRC) begin
         slot = slot + 16'h0001;
      end
      if (src >= `FIC_VEC_GAP2_SRC) begin
         slot = slot + 16'h0001;
      end
      return `FIC_VEC_BASE + (slot << `FIC_VEC_STEP_SHIFT);
   endfunction : vec_of

   // One bit per source index from a pair of register bytes. Enable and
   // both priority pairs share these positions, so one map serves all
   // three and they cannot drift apart.
   function automatic logic [12:0] src_bits(input logic [7:0] r0,
                                            input logic [7:0] r1);
      logic [12:0] b;
      b[0] = r0[0]; // external 0
      b[1] = r0[1]; // timer 0
      b[2] = r0[2]; // external 1
      b[3] = r0[3]; // timer 1
      b[4] = r0[4]; // serial
      b[5] = r0[5]; // brownout
      b[6] = r1[0]; // i2c
      b[7] = r1[1]; // keyboard
      b[8] = r1[2]; // comparator 2
      b[9] = r0[6]; // watchdog
      b[10] = r1[4]; // converter
      b[11] = r1[5]; // comparator 1
      b[12] = r1[7]; // timer i
      return b;
   endfunction : src_bits

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic mc_tick;
      logic [1:0] edge_hit;
      logic [12:0] raw;
      logic [12:0] en;
      logic [12:0] pend;
      logic [12:0] prio_h;
      logic [12:0] prio_l;
      logic [2:0] cur;
      logic found;
      fic_src_t pick;
      fic_level_t pick_lvl;
      logic setup;
      logic access;
      logic mapped;
      logic [31:0] rdata;
      logic wake_pd;
      logic wake_idle;

      // Every field keeps its value unless a branch below changes it
      s_next = s_reg;
      mc_tick = 1'b0;
      edge_hit = 2'b00;
      raw = '0;
      en = '0;
      pend = '0;
      prio_h = '0;
      prio_l = '0;
      cur = 3'b111;
      found = 1'b0;
      pick = '0;
      pick_lvl = '0;
      setup = 1'b0;
      access = 1'b0;
      mapped = 1'b0;
      rdata = '0;
      wake_pd = 1'b0;
      wake_idle = 1'b0;

      // Machine-cycle divider: pins are only looked at once per cycle
      mc_tick = (s_reg.mc_cnt == `FIC_MC_CLKS - 3'd1);
      s_next.mc_cnt = mc_tick ? 3'd0 : s_reg.mc_cnt + 3'd1;
      if (mc_tick) begin
         // Edge needs the previous sample high and this one low
         edge_hit = s_reg.pin_sample & ~i_ext_irq_pin_n;
         s_next.pin_sample = i_ext_irq_pin_n;
      end

      // ==========================================================
      // APB slave: one setup cycle, then a one-cycle access phase
      setup = i_psel && !i_penable;
      access = i_psel && i_penable && s_reg.pready;
      unique case (i_paddr)
         `FIC_OFS_ENABLE_ZERO: rdata = {24'h0, s_reg.enable_reg_zero};
         `FIC_OFS_ENABLE_ONE: rdata = {24'h0, s_reg.enable_reg_one};
         `FIC_OFS_PRIO_LOW_ZERO: rdata = {24'h0, s_reg.prio_low_reg_zero};
         `FIC_OFS_PRIO_HIGH_ZERO: rdata = {24'h0, s_reg.prio_high_reg_zero};
         `FIC_OFS_PRIO_LOW_ONE: rdata = {24'h0, s_reg.prio_low_reg_one};
         `FIC_OFS_PRIO_HIGH_ONE: rdata = {24'h0, s_reg.prio_high_reg_one};
         `FIC_OFS_TIMER_CONTROL: begin
            rdata[`FIC_TIMER_CONTROL_REG_TYPE_LSB +: 2] = s_reg.ext_trigger_type;
            rdata[`FIC_TIMER_CONTROL_REG_FLAG_LSB +: 2] = s_reg.ext_request_flag;
         end
         `FIC_OFS_STATUS: begin
            rdata[3:0] = s_reg.active;
            rdata[`FIC_STAT_VEC_LSB +: 16] = s_reg.irq_vector;
            rdata[`FIC_STAT_REQ_BIT] = s_reg.irq_req;
            rdata[`FIC_STAT_LVL_LSB +: 2] = s_reg.irq_level;
         end
         default: rdata = '0;
      endcase
      mapped = (i_paddr[1:0] == 2'b00) && (i_paddr <= `FIC_OFS_STATUS);
      s_next.pready = setup;
      s_next.pslverr = setup && !mapped;
      if (setup) begin
         s_next.prdata = mapped ? rdata : '0;
      end
      if (access && i_pwrite) begin
         unique case (i_paddr)
            `FIC_OFS_ENABLE_ZERO: s_next.enable_reg_zero = i_pwdata[7:0];
            `FIC_OFS_ENABLE_ONE: s_next.enable_reg_one = i_pwdata[7:0];
            `FIC_OFS_PRIO_LOW_ZERO: s_next.prio_low_reg_zero = i_pwdata[7:0];
            `FIC_OFS_PRIO_HIGH_ZERO:
               s_next.prio_high_reg_zero = i_pwdata[7:0];
            `FIC_OFS_PRIO_LOW_ONE: s_next.prio_low_reg_one = i_pwdata[7:0];
            `FIC_OFS_PRIO_HIGH_ONE: s_next.prio_high_reg_one = i_pwdata[7:0];
            `FIC_OFS_TIMER_CONTROL: begin
               s_next.ext_trigger_type =
                  i_pwdata[`FIC_TIMER_CONTROL_REG_TYPE_LSB +: 2];
               s_next.ext_request_flag =
                  i_pwdata[`FIC_TIMER_CONTROL_REG_FLAG_LSB +: 2];
            end
            default: ;
         endcase
      end

      // ==========================================================
      // Return from a routine restores the level below it
      cur = top_active(s_reg.active);
      if (i_irq_return && !cur[2]) begin
         s_next.active[cur[1:0]] = 1'b0;
      end

      // Entry into a routine marks its level in service
      if (i_irq_ack && s_reg.irq_req) begin
         s_next.active[s_reg.irq_level] = 1'b1;
         if (s_reg.irq_src == 4'd0 && s_reg.ext_trigger_type[0]) begin
            s_next.ext_request_flag[0] = 1'b0;
         end
         if (s_reg.irq_src == 4'd2 && s_reg.ext_trigger_type[1]) begin
            s_next.ext_request_flag[1] = 1'b0;
         end
      end

      // External flags: level mode tracks the pin, edge mode is sticky.
      // A new edge wins over a write or an entry clear in the same cycle.
      for (int k = 0; k < 2; k++) begin
         if (!s_next.ext_trigger_type[k]) begin
            s_next.ext_request_flag[k] = !s_reg.pin_sample[k];
         end else if (edge_hit[k]) begin
            s_next.ext_request_flag[k] = 1'b1;
         end
      end

      // ==========================================================
      // Source requests, enables and levels by source index
      raw[0] = s_next.ext_request_flag[0];
      raw[1] = i_timer0_req;
      raw[2] = s_next.ext_request_flag[1];
      raw[3] = i_timer1_req;
      raw[4] = i_serial_tx_flag | i_serial_rx_flag;
      raw[5] = i_bod_req;
      raw[6] = i_i2c_req;
      raw[7] = i_kbd_req;
      raw[8] = i_cmp2_req;
      raw[9] = i_wdt_req;
      raw[10] = i_adc_req;
      raw[11] = i_cmp1_req;
      raw[12] = i_timer_i_req;
      en = src_bits(s_next.enable_reg_zero, s_next.enable_reg_one);
      prio_h = src_bits(s_next.prio_high_reg_zero,
                        s_next.prio_high_reg_one);
      prio_l = src_bits(s_next.prio_low_reg_zero,
                        s_next.prio_low_reg_one);
      pend = raw & en;

      // Highest level first; rank order only breaks ties inside a level
      for (int lv = 3; lv >= 0; lv--) begin
         for (int r = 0; r < 13; r++) begin
            if (!found && pend[FIC_RANK[r]] &&
                {prio_h[FIC_RANK[r]], prio_l[FIC_RANK[r]]} == 2'(lv)) begin
               found = 1'b1;
               pick = FIC_RANK[r];
               pick_lvl = 2'(lv);
            end
         end
      end

      // Preempt only above the running level; top level blocks everything
      cur = top_active(s_next.active);
      s_next.irq_req = found &&
         s_next.enable_reg_zero[`FIC_GLOBAL_EN_BIT] &&
         (cur[2] || {1'b0, pick_lvl} > cur);
      s_next.irq_src = pick;
      s_next.irq_level = pick_lvl;
      s_next.irq_vector = found ? vec_of(pick) : '0;

      // Wake: any enabled source from idle, restricted set from power-down
      wake_pd = i_power_down && |(pend & `FIC_WAKE_MASK);
      wake_idle = i_idle && |pend;
      s_next.wake = wake_pd || wake_idle;
   end

   // ==========================================================
   // State register
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         s_reg <= '0;
         s_reg.enable_reg_zero <= `FIC_RST_BYTE;
         s_reg.enable_reg_one <= `FIC_RST_BYTE;
         s_reg.prio_low_reg_zero <= `FIC_RST_BYTE;
         s_reg.prio_high_reg_zero <= `FIC_RST_BYTE;
         s_reg.prio_low_reg_one <= `FIC_RST_BYTE;
         s_reg.prio_high_reg_one <= `FIC_RST_BYTE;
         s_reg.pin_sample <= `FIC_RST_PINS;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // Outputs straight from the state register
   assign o_prdata = s_reg.prdata;
   assign o_pready = s_reg.pready;
   assign o_pslverr = s_reg.pslverr;
   assign o_irq_req = s_reg.irq_req;
   assign o_irq_vector = s_reg.irq_vector;
   assign o_irq_level = s_reg.irq_level;
   assign o_wake = s_reg.wake;

endmodule : fic_top

// ===== common/fic_regs.svh
// Register offsets, bit positions, reset values and timing counts
`ifndef FIC_REGS_SVH
`define FIC_REGS_SVH

// ==========================================================
// Register byte offsets
`define FIC_OFS_ENABLE_ZERO 8'h00
`define FIC_OFS_ENABLE_ONE 8'h04
`define FIC_OFS_PRIO_LOW_ZERO 8'h08
`define FIC_OFS_PRIO_HIGH_ZERO 8'h0c
`define FIC_OFS_PRIO_LOW_ONE 8'h10
`define FIC_OFS_PRIO_HIGH_ONE 8'h14
`define FIC_OFS_TIMER_CONTROL 8'h18
`define FIC_OFS_STATUS 8'h1c

// ==========================================================
// Field positions
`define FIC_GLOBAL_EN_BIT 7
`define FIC_TIMER_CONTROL_REG_TYPE_LSB 0
`define FIC_TIMER_CONTROL_REG_FLAG_LSB 2
`define FIC_STAT_VEC_LSB 8
`define FIC_STAT_REQ_BIT 24
`define FIC_STAT_LVL_LSB 25

// ==========================================================
// Reset values
`define FIC_RST_BYTE 8'h00
`define FIC_RST_PINS 2'b11

// ==========================================================
// Timing and vectors
`define FIC_MC_CLKS 3'd6
`define FIC_VEC_BASE 16'h0003
`define FIC_VEC_STEP_SHIFT 3
`define FIC_VEC_GAP_SRC 4'd9
`define FIC_VEC_GAP2_SRC 4'd12
`define FIC_WAKE_MASK 13'h0fa5

`endif

// ===== common/fic_pkg.sv
// Types shared by the interrupt controller
package fic_pkg;
   typedef logic [1:0] fic_level_t;
   typedef logic [3:0] fic_src_t;

   // Source index 0..12: ext0, timer0, ext1, timer1, serial, brownout,
   // i2c, keyboard, comparator 2, watchdog, converter, comparator 1,
   // timer i. Listed here in fixed tie-break order, first wins.
   localparam fic_src_t FIC_RANK [13] = '{
      4'd0, 4'd5, 4'd9, 4'd1, 4'd6, 4'd10, 4'd2,
      4'd7, 4'd11, 4'd3, 4'd8, 4'd4, 4'd12};

   typedef struct packed {
      logic [7:0] enable_reg_zero;
      logic [7:0] enable_reg_one;
      logic [7:0] prio_low_reg_zero;
      logic [7:0] prio_high_reg_zero;
      logic [7:0] prio_low_reg_one;
      logic [7:0] prio_high_reg_one;
      logic [1:0] ext_trigger_type;
      logic [1:0] ext_request_flag;
      logic [1:0] pin_sample;
      logic [2:0] mc_cnt;
      logic [3:0] active;
      logic irq_req;
      logic [15:0] irq_vector;
      fic_level_t irq_level;
      fic_src_t irq_src;
      logic wake;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } fic_state_t;
endpackage : fic_pkg

// ===== verif/fic_top_assertions.sv
// Port assertions for the interrupt controller
`timescale 1ns/1ps
`include "fic_regs.svh"
module fic_checker
   import fic_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // APB
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // CPU side
   input wire logic i_irq_ack,
   input wire logic i_irq_return,
   input wire logic o_irq_req,
   input wire logic [15:0] o_irq_vector,
   input wire fic_level_t o_irq_level
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   // ==========
   // Global enable as software last wrote it
   logic glob_reg;
   always_ff @(posedge i_mclk) begin
      if (i_rst)
         glob_reg <= 1'b0;
      else if (i_psel && i_penable && o_pready && i_pwrite &&
               i_paddr == `FIC_OFS_ENABLE_ZERO)
         glob_reg <= i_pwdata[`FIC_GLOBAL_EN_BIT];
   end
   chk_apb_answer: assert property (i_psel && !i_penable |=> o_pready)
      else $error("no ready");
   chk_ready_pulse: assert property (o_pready |=> !o_pready)
      else $error("ready too long");
   chk_err_ready: assert property (o_pslverr |-> o_pready)
      else $error("stray error");
   chk_reset_quiet: assert property (disable iff (1'b0)
      i_rst |=> !o_irq_req && !o_pready) else $error("busy in reset");
   chk_global_gate: assert property (
      !glob_reg [*2] |-> !o_irq_req) else $error("request while off");
   chk_vector_grid: assert property (
      o_irq_req |-> o_irq_vector[2:0] == 3'h3 && o_irq_vector <= 16'h0073
      && o_irq_vector != 16'h004b && o_irq_vector != 16'h006b)
      else $error("bad vector");
   chk_top_level: assert property (
      o_irq_req && i_irq_ack && !i_irq_return && o_irq_level == 2'd3
      |=> !o_irq_req) else $error("top routine interrupted");
   chk_preempt_higher: assert property (
      o_irq_req && i_irq_ack && !i_irq_return
      |=> !o_irq_req || o_irq_level > $past(o_irq_level))
      else $error("preempt not higher");
endmodule : fic_checker

bind fic_top fic_checker u_chk (.*);

// ===== verif/fic_pin_model.sv
// External interrupt pin driver with a minimum hold per level
`timescale 1ns/1ps
module fic_pin_model (
   // Clock
   input wire logic i_mclk,
   // Wanted levels and pins, active low
   input wire logic [1:0] i_want_n,
   output logic [1:0] o_pin_n
);
   logic [2:0] hold_reg;
   // Pins idle high through their pull-ups; a new level waits out the
   // hold, so no glitch reaches a pin. One process drives both.
   initial begin
      o_pin_n = 2'b11;
      hold_reg = 3'd0;
      forever begin
         @(posedge i_mclk);
         if (hold_reg != 3'd0) begin
            hold_reg <= hold_reg - 3'd1;
         end else if (i_want_n !== o_pin_n) begin
            o_pin_n <= i_want_n;
            hold_reg <= 3'd6;
         end
      end
   end
endmodule : fic_pin_model

// ===== verif/fic_top_tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "fic_regs.svh"
module fic_top_tb;
   import fic_pkg::*;
   // ==========
   // Signals named after the ports they meet
   logic i_mclk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
   logic i_irq_ack, i_irq_return, i_idle, i_power_down, o_irq_req, o_wake;
   logic [7:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata;
   logic [15:0] o_irq_vector;
   fic_level_t o_irq_level;
   logic [1:0] want_n, pin_n;
   logic [11:0] pr;
   int failures = 0;
   int n_checks = 0;
   fic_pin_model u_pins (.i_mclk(i_mclk), .i_want_n(want_n), .o_pin_n(pin_n));
   // Peripheral requests packed in port order, not by source index, to keep stimulus short
   fic_top DUT (.*, .i_ext_irq_pin_n(pin_n),
      .i_timer0_req(pr[0]), .i_timer1_req(pr[1]),
      .i_serial_tx_flag(pr[2]), .i_serial_rx_flag(pr[3]),
      .i_bod_req(pr[4]), .i_i2c_req(pr[5]), .i_kbd_req(pr[6]),
      .i_cmp2_req(pr[7]), .i_wdt_req(pr[8]), .i_adc_req(pr[9]),
      .i_cmp1_req(pr[10]), .i_timer_i_req(pr[11]));
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d,
                      logic [31:0] exp, logic err);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      // Only the watchdog ends a wait for the slave
      do begin
         @(posedge i_mclk);
      end while (o_pready !== 1'b1);
      if (!wr)
         chk("prdata", exp, o_prdata);
      chk("pslverr", 32'(err), 32'(o_pslverr));
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_mclk);
   endtask : apb
   task automatic wreq(logic v);
      int n;
      n = 0;
      repeat (2) @(posedge i_mclk);
      while (o_irq_req !== v && n < 40) begin
         @(posedge i_mclk);
         n++;
      end
      chk("irq_req", 32'(v), 32'(o_irq_req));
   endtask : wreq
   task automatic see(logic [15:0] v, fic_level_t l);
      wreq(1'b1);
      chk("irq_vector", 32'(v), 32'(o_irq_vector));
      chk("irq_level", 32'(l), 32'(o_irq_level));
   endtask : see
   task automatic pulse(logic a, logic r);
      i_irq_ack <= a;
      i_irq_return <= r;
      @(posedge i_mclk);
      i_irq_ack <= 1'b0;
      i_irq_return <= 1'b0;
      @(posedge i_mclk);
   endtask : pulse
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      i_mclk = 1'b0;
      forever #4 i_mclk = ~i_mclk;
   end
   initial begin
      repeat (5000) @(posedge i_mclk);
      failures++;
      tally_and_finish();
   end
   initial begin
      i_rst = 1'b1;
      {i_psel, i_penable, i_pwrite, i_irq_ack, i_irq_return} = '0;
      {i_idle, i_power_down, i_paddr, i_pwdata, pr} = '0;
      want_n = 2'b11;
      repeat (8) @(posedge i_mclk);
      i_rst <= 1'b0;
      @(posedge i_mclk);
      apb(0, `FIC_OFS_ENABLE_ZERO, 0, 0, 0);
      apb(0, 8'h20, 0, 0, 1);
      apb(1, `FIC_OFS_ENABLE_ZERO, 32'hff, 0, 0);
      apb(1, `FIC_OFS_ENABLE_ONE, 32'hb7, 0, 0);
      apb(0, `FIC_OFS_ENABLE_ONE, 0, 32'hb7, 0);
      $display("test registers done");
      pr <= 12'h111;
      see(16'h002b, 2'd0);
      apb(1, `FIC_OFS_PRIO_HIGH_ZERO, 32'h02, 0, 0);
      see(16'h000b, 2'd2);
      apb(1, `FIC_OFS_PRIO_LOW_ZERO, 32'h02, 0, 0);
      see(16'h000b, 2'd3);
      pr[0] <= 1'b0;
      pulse(1'b1, 1'b0);
      wreq(1'b0);
      pulse(1'b0, 1'b1);
      see(16'h002b, 2'd0);
      pr[4] <= 1'b0;
      pulse(1'b1, 1'b0);
      wreq(1'b0);
      pulse(1'b0, 1'b1);
      see(16'h0053, 2'd0);
      pr <= 12'h000;
      pulse(1'b1, 1'b0);
      pulse(1'b0, 1'b1);
      $display("test priority done");
      pr[3] <= 1'b1;
      see(16'h0023, 2'd0);
      pr <= 12'h004;
      see(16'h0023, 2'd0);
      apb(1, `FIC_OFS_ENABLE_ZERO, 32'h7f, 0, 0);
      wreq(1'b0);
      pr <= 12'h000;
      apb(1, `FIC_OFS_ENABLE_ZERO, 32'hff, 0, 0);
      pr <= 12'h800;
      see(16'h0073, 2'd0);
      i_power_down <= 1'b1;
      repeat (3) @(posedge i_mclk);
      chk("wake", 0, 32'(o_wake));
      pr <= 12'h200;
      repeat (3) @(posedge i_mclk);
      chk("wake", 1, 32'(o_wake));
      i_power_down <= 1'b0;
      pr <= 12'h800;
      i_idle <= 1'b1;
      repeat (3) @(posedge i_mclk);
      chk("wake", 1, 32'(o_wake));
      i_idle <= 1'b0;
      apb(1, `FIC_OFS_ENABLE_ONE, 32'h37, 0, 0);
      wreq(1'b0);
      pr <= 12'h000;
      $display("test enables done");
      want_n <= 2'b10;
      i_power_down <= 1'b1;
      see(16'h0003, 2'd0);
      chk("wake", 1, 32'(o_wake));
      pulse(1'b1, 1'b0);
      pulse(1'b0, 1'b1);
      see(16'h0003, 2'd0);
      want_n <= 2'b11;
      i_power_down <= 1'b0;
      wreq(1'b0);
      apb(1, `FIC_OFS_TIMER_CONTROL, 32'h02, 0, 0);
      want_n <= 2'b01;
      repeat (14) @(posedge i_mclk);
      want_n <= 2'b11;
      see(16'h0013, 2'd0);
      pulse(1'b1, 1'b0);
      pulse(1'b0, 1'b1);
      repeat (8) @(posedge i_mclk);
      chk("irq_req", 0, 32'(o_irq_req));
      apb(0, `FIC_OFS_TIMER_CONTROL, 0, 32'h02, 0);
      $display("test external pins done");
      tally_and_finish();
   end
endmodule : fic_top_tb
